/* src/dpmc_host.sv */
`timescale 1ns/1ns
module dpmc_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // axi4-lite write channels
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // memory port pins
  output logic [12:0] port_addr,
  input wire logic [15:0] port_data_in,
  output logic [15:0] port_data_out,
  output logic port_data_oe,
  output logic port_ce_n,
  output logic port_flag_space_select_n,
  output logic port_oe_n,
  output logic port_rw_n,
  output logic port_ub_n,
  output logic port_lb_n,
  // busy and mailbox flag from the device side
  input wire logic [1:0] port_busy_n,
  input wire logic left_mailbox_flag_n,
  // role straps for a two-device width array
  output logic [1:0] role_select,
  output logic slave_busy_n
);
  dpmc_pkg::dpmc_state_type state;
  dpmc_pkg::dpmc_state_type next_state;
  logic [5:0] ctrl;
  logic [12:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic done_flag;
  logic collision_flag;
  logic sem_owned;
  logic mbx_pending;
  logic take_phase;
  // read-back of a take has finished, so the next recovery ends the access
  logic done_flag_pend;
  logic [7:0] sel_cnt;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic timer_load;
  logic [7:0] timer_value;
  logic expired;

  // lane merge used by every writable register
  function automatic logic [31:0] dpmc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : dpmc_merge

  // axi write decode
  wire do_write = aw_held && w_held && !s_bvalid;
  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire hit_ctrl = (aw_addr == dpmc_pkg::REG_CTRL);
  wire hit_addr = (aw_addr == dpmc_pkg::REG_ADDR);
  wire hit_wdata = (aw_addr == dpmc_pkg::REG_WDATA);
  wire hit_status = (aw_addr == dpmc_pkg::REG_STATUS);
  wire hit_rdata = (aw_addr == dpmc_pkg::REG_RDATA);
  wire w_mapped = hit_ctrl || hit_addr || hit_wdata || hit_status || hit_rdata;
  wire [31:0] ctrl_merged = dpmc_merge({26'h0000000, ctrl}, w_data, w_strb);
  wire [31:0] addr_merged = dpmc_merge({19'h00000, addr_reg}, w_data, w_strb);
  wire [31:0] wdata_merged = dpmc_merge({16'h0000, wdata_reg}, w_data, w_strb);
  wire [31:0] status_w1c = dpmc_merge(32'h00000000, w_data, w_strb);
  wire op_idle = (state == dpmc_pkg::ST_IDLE);
  // settings are frozen while an access runs so the pins never shift mid-cycle
  wire wr_ctrl = do_write && hit_ctrl && op_idle;
  wire wr_addr = do_write && hit_addr && op_idle;
  wire wr_wdata = do_write && hit_wdata && op_idle;
  wire start_go = wr_ctrl && ctrl_merged[dpmc_pkg::CTRL_START];
  wire next_aw_held = (aw_held && !do_write) || aw_take;
  wire next_w_held = (w_held && !do_write) || w_take;
  wire next_bvalid = (s_bvalid && !s_bready) || do_write;

  // axi read decode
  wire ar_take = s_arvalid && s_arready;
  wire next_rvalid = (s_rvalid && !s_rready) || ar_take;
  wire [31:0] status_word = {27'h0000000, mbx_pending, sem_owned, collision_flag,
                             done_flag, !op_idle};
  wire r_mapped = (s_araddr == dpmc_pkg::REG_CTRL) || (s_araddr == dpmc_pkg::REG_ADDR) ||
                  (s_araddr == dpmc_pkg::REG_WDATA) || (s_araddr == dpmc_pkg::REG_RDATA) ||
                  (s_araddr == dpmc_pkg::REG_STATUS);
  wire [31:0] read_mux =
    (s_araddr == dpmc_pkg::REG_CTRL) ? {26'h0000000, ctrl} :
    (s_araddr == dpmc_pkg::REG_ADDR) ? {19'h00000, addr_reg} :
    (s_araddr == dpmc_pkg::REG_WDATA) ? {16'h0000, wdata_reg} :
    (s_araddr == dpmc_pkg::REG_RDATA) ? {16'h0000, rdata_reg} :
    (s_araddr == dpmc_pkg::REG_STATUS) ? status_word : 32'h00000000;

  // operation decode
  wire [1:0] op = ctrl[dpmc_pkg::CTRL_OP_LSB +: 2];
  wire op_sem = (op == dpmc_pkg::OP_SEM_TAKE) || (op == dpmc_pkg::OP_SEM_RELEASE);
  // a take is a write of zero followed by a read-back, never the other order
  wire op_writes = (op == dpmc_pkg::OP_WRITE) || (op == dpmc_pkg::OP_SEM_RELEASE) ||
                   ((op == dpmc_pkg::OP_SEM_TAKE) && !take_phase);
  wire busy_ok = &port_busy_n;
  wire arb_stall = !op_sem && !busy_ok;
  wire read_end = (state == dpmc_pkg::ST_READ) && expired;
  wire take_read_end = read_end && (op == dpmc_pkg::OP_SEM_TAKE);
  wire collision_set = (state == dpmc_pkg::ST_ARB) && expired && arb_stall;
  // a take reports done only after its read-back half has finished
  wire done_set = (state == dpmc_pkg::ST_RECOVER) && expired &&
                  !((op == dpmc_pkg::OP_SEM_TAKE) && !done_flag_pend);
  wire take_rearm = (state == dpmc_pkg::ST_WPULSE) && expired &&
                    (op == dpmc_pkg::OP_SEM_TAKE);
  wire next_active = (next_state == dpmc_pkg::ST_ARB) ||
                     (next_state == dpmc_pkg::ST_WPULSE) ||
                     (next_state == dpmc_pkg::ST_READ);
  // semaphore writes use bit zero only; replicated so any lane works
  wire [15:0] drive_word = op_sem ? {16{op == dpmc_pkg::OP_SEM_RELEASE}} : wdata_reg;
  wire next_mbx = ctrl[dpmc_pkg::CTRL_MAILBOX_USE] && !left_mailbox_flag_n;

  // access sequencer: select, wait for the busy decision, then strobe
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = dpmc_pkg::ARB_CYCLES;
    case (state)
      dpmc_pkg::ST_IDLE: begin
        if (start_go) begin
          next_state = dpmc_pkg::ST_ARB;
          timer_load = 1'b1;
        end
      end
      dpmc_pkg::ST_ARB: begin
        // a busy port waits with its write held back until the device frees it
        if (expired && !arb_stall) begin
          timer_load = 1'b1;
          if (op_writes) begin
            next_state = dpmc_pkg::ST_WPULSE;
            timer_value = dpmc_pkg::WPULSE_CYCLES;
          end else begin
            next_state = dpmc_pkg::ST_READ;
            timer_value = dpmc_pkg::ACCESS_CYCLES;
          end
        end
      end
      dpmc_pkg::ST_WPULSE, dpmc_pkg::ST_READ: begin
        if (expired) begin
          next_state = dpmc_pkg::ST_RECOVER;
          timer_load = 1'b1;
          timer_value = dpmc_pkg::RECOVER_CYCLES;
        end
      end
      dpmc_pkg::ST_RECOVER: begin
        if (expired) begin
          timer_load = 1'b1;
          next_state = (take_phase && !done_flag_pend) ? dpmc_pkg::ST_ARB
                                                       : dpmc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dpmc_pkg::ST_IDLE;
      end
    endcase
  end

  dpmc_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(timer_load),
    .value(timer_value),
    .expired(expired)
  );

  // bus handshake state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= dpmc_pkg::RESP_OKAY;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rresp <= dpmc_pkg::RESP_OKAY;
      s_rdata <= 32'h00000000;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_awready <= !next_aw_held && !next_bvalid;
      s_wready <= !next_w_held && !next_bvalid;
      s_bvalid <= next_bvalid;
      s_arready <= !next_rvalid;
      s_rvalid <= next_rvalid;
      if (aw_take) begin
        aw_addr <= s_awaddr;
      end
      if (w_take) begin
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (do_write) begin
        s_bresp <= w_mapped ? dpmc_pkg::RESP_OKAY : dpmc_pkg::RESP_SLVERR;
      end
      if (ar_take) begin
        s_rdata <= read_mux;
        s_rresp <= r_mapped ? dpmc_pkg::RESP_OKAY : dpmc_pkg::RESP_SLVERR;
      end
    end
  end

  // software registers; sticky bits let a same-cycle set beat the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= dpmc_pkg::CTRL_RESET;
      addr_reg <= 13'h0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      done_flag <= 1'b0;
      collision_flag <= 1'b0;
      sem_owned <= 1'b0;
      mbx_pending <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_merged[5:0] & dpmc_pkg::CTRL_STORE_MASK;
        ctrl[dpmc_pkg::CTRL_OP_LSB +: 2] <= ctrl_merged[1:0];
      end
      if (wr_addr) begin
        addr_reg <= addr_merged[12:0];
      end
      if (wr_wdata) begin
        wdata_reg <= wdata_merged[15:0];
      end
      if (read_end) begin
        rdata_reg <= port_data_in;
      end
      done_flag <= (done_flag && !(do_write && hit_status && status_w1c[dpmc_pkg::STAT_DONE]))
                   || done_set;
      collision_flag <= (collision_flag &&
                         !(do_write && hit_status && status_w1c[dpmc_pkg::STAT_COLLISION]))
                        || collision_set;
      // token is ours when the read-back shows zero on bit zero
      if (take_read_end) begin
        sem_owned <= !port_data_in[0];
      end else if (state == dpmc_pkg::ST_RECOVER && op == dpmc_pkg::OP_SEM_RELEASE) begin
        sem_owned <= 1'b0;
      end
      mbx_pending <= next_mbx;
    end
  end

  // sequencer state and pin drive; pins follow the next state so they are registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= dpmc_pkg::ST_IDLE;
      take_phase <= 1'b0;
      done_flag_pend <= 1'b0;
      sel_cnt <= 8'h00;
      port_addr <= 13'h0000;
      port_data_out <= 16'h0000;
      port_data_oe <= 1'b0;
      port_ce_n <= 1'b1;
      port_flag_space_select_n <= 1'b1;
      port_oe_n <= 1'b1;
      port_rw_n <= 1'b1;
      port_ub_n <= 1'b1;
      port_lb_n <= 1'b1;
      role_select <= 2'h1;
      slave_busy_n <= 1'b1;
    end else begin
      state <= next_state;
      take_phase <= (take_phase || take_rearm) && (next_state != dpmc_pkg::ST_IDLE);
      done_flag_pend <= (done_flag_pend || take_read_end) && (next_state != dpmc_pkg::ST_IDLE);
      sel_cnt <= !next_active ? 8'h00 : ((sel_cnt == 8'hFF) ? sel_cnt : sel_cnt + 8'h01);
      port_addr <= addr_reg;
      port_data_out <= drive_word;
      // data stays driven through recovery so it holds past the rising write strobe
      port_data_oe <= (next_state == dpmc_pkg::ST_WPULSE) ||
                      (port_data_oe && next_state == dpmc_pkg::ST_RECOVER);
      port_ce_n <= !(next_active && !op_sem);
      port_flag_space_select_n <= !(next_active && op_sem);
      port_oe_n <= !(next_state == dpmc_pkg::ST_READ);
      port_rw_n <= !(next_state == dpmc_pkg::ST_WPULSE);
      port_ub_n <= !next_active;
      port_lb_n <= !next_active;
      // exactly one device of the pair takes the master strap
      role_select <= ctrl[dpmc_pkg::CTRL_MASTER_SEL] ? 2'h2 : 2'h1;
      slave_busy_n <= !ctrl[dpmc_pkg::CTRL_SLAVE_INHIBIT];
    end
  end

  sel_before_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(port_rw_n) |-> (sel_cnt >= dpmc_pkg::ARB_CYCLES) && !(port_ce_n && port_flag_space_select_n))
    else $error("write strobe before busy decision window");
  write_holds_select_a: assert property (@(posedge ref_clk) disable iff (reset)
    !port_rw_n |-> $stable(port_addr) && !(port_ce_n && port_flag_space_select_n))
    else $error("address or select moved during write strobe");
  busy_stall_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state == dpmc_pkg::ST_ARB && expired && !op_sem && port_busy_n != 2'h3)
    |=> state == dpmc_pkg::ST_ARB && port_rw_n)
    else $error("access went ahead while a bank signalled busy");
  one_master_a: assert property (@(posedge ref_clk) disable iff (reset)
    $onehot(role_select))
    else $error("role straps not exactly one master");
  slave_inhibit_a: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(ctrl[dpmc_pkg::CTRL_SLAVE_INHIBIT])
    |=> slave_busy_n == !$past(ctrl[dpmc_pkg::CTRL_SLAVE_INHIBIT]))
    else $error("slave busy strap did not follow inhibit setting");
  sem_take_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(port_rw_n) && !port_flag_space_select_n && op == dpmc_pkg::OP_SEM_TAKE
    |-> port_data_out == 16'h0000 ##1 1'b1)
    else $error("semaphore take did not write zero");
  sem_release_one_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(port_rw_n) && !port_flag_space_select_n && op == dpmc_pkg::OP_SEM_RELEASE
    |-> port_data_out == 16'hFFFF)
    else $error("semaphore release did not write one");
  mailbox_plain_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ctrl[dpmc_pkg::CTRL_MAILBOX_USE] ##1 !ctrl[dpmc_pkg::CTRL_MAILBOX_USE] |-> !mbx_pending)
    else $error("mailbox shown while mailbox use is off");
endmodule : dpmc_host

/* src/dpmc_pkg.sv */
package dpmc_pkg;
  // clock and pin timing, times in ns, counts derived from the clock rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ARB_NS = 20;
  localparam int T_WPULSE_NS = 50;
  localparam int T_ACCESS_NS = 70;
  localparam int T_RECOVER_NS = 20;

  // least times round up to whole cycles, never below one
  function automatic logic [7:0] dpmc_cycles_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction : dpmc_cycles_up

  localparam logic [7:0] ARB_CYCLES = dpmc_cycles_up(T_ARB_NS);
  localparam logic [7:0] WPULSE_CYCLES = dpmc_cycles_up(T_WPULSE_NS);
  localparam logic [7:0] ACCESS_CYCLES = dpmc_cycles_up(T_ACCESS_NS);
  localparam logic [7:0] RECOVER_CYCLES = dpmc_cycles_up(T_RECOVER_NS);

  // mailbox words of the far device
  localparam logic [12:0] MAILBOX_OWN_ADDR = 13'h1FFE;
  localparam logic [12:0] MAILBOX_PEER_ADDR = 13'h1FFF;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_START = 2;
  localparam int CTRL_MAILBOX_USE = 3;
  localparam int CTRL_MASTER_SEL = 4;
  localparam int CTRL_SLAVE_INHIBIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [5:0] CTRL_STORE_MASK = 6'h3B;

  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_COLLISION = 2;
  localparam int STAT_SEM_OWNED = 3;
  localparam int STAT_MAILBOX = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_SEM_TAKE,
    OP_SEM_RELEASE
  } dpmc_op_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARB,
    ST_WPULSE,
    ST_READ,
    ST_RECOVER
  } dpmc_state_type;
endpackage : dpmc_pkg

/* src/dpmc_timer.sv */
`timescale 1ns/1ns
module dpmc_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // load and state
  input wire logic load,
  input wire logic [7:0] value,
  output logic expired
);
  logic [7:0] count;

  assign expired = (count == 8'h00);

  // counts down to zero after a load of the phase length minus one
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= 8'h00;
    end else if (load) begin
      count <= value - 8'h01;
    end else if (!expired) begin
      count <= count - 8'h01;
    end
  end
endmodule : dpmc_timer

/* test/dpmc_dev_model.sv */
`timescale 1ns/1ns
module dpmc_dev_model (
  // peer-side event clock
  input wire logic ref_clk,
  // port pins to and from the controller
  input wire logic [12:0] port_addr,
  input wire logic [15:0] port_data_out,
  input wire logic port_data_oe,
  input wire logic port_ce_n,
  input wire logic port_flag_space_select_n,
  input wire logic port_oe_n,
  input wire logic port_rw_n,
  output logic [15:0] port_data_in,
  output logic [1:0] port_busy_n,
  output logic left_mailbox_flag_n,
  output logic right_mailbox_flag_n,
  // peer port behaviour set by the bench
  input wire logic peer_active,
  input wire logic [12:0] peer_addr,
  input wire logic peer_mbox_write,
  input wire logic [7:0] peer_sem_held
);
  logic [15:0] mem [0:8191];
  logic [7:0] sem_own_n;
  logic [15:0] last_out;
  logic collide;
  logic sel_mem;
  logic sel_sem;

  // flags and latches start free, as software would initialise them
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    sem_own_n = 8'hFF;
    left_mailbox_flag_n = 1'b1;
    right_mailbox_flag_n = 1'b1;
    last_out = 16'h0000;
  end

  // the peer was stable first, so this side loses; second bank never busy
  assign collide = peer_active && !port_ce_n && (port_addr == peer_addr);
  assign port_busy_n = {1'b1, ~collide};
  assign sel_mem = !port_ce_n && !port_oe_n;
  assign sel_sem = !port_flag_space_select_n && !port_oe_n;
  // a released bus shows the inverse of the last value, never a stale copy
  assign port_data_in = sel_sem ? {16{sem_own_n[port_addr[2:0]]}} :
                        sel_mem ? mem[port_addr] : ~last_out;

  always @(port_data_in) begin
    if (sel_mem || sel_sem) last_out = port_data_in;
  end

  // select rises with the strobe, so writes are taken on each clock while both are low
  always @(posedge ref_clk) begin
    if (!port_ce_n && !port_rw_n && port_data_oe && !collide) begin
      mem[port_addr] <= port_data_out;
    end
    if (!port_flag_space_select_n && !port_rw_n && port_data_oe) begin
      if (port_data_out[0]) sem_own_n[port_addr[2:0]] <= 1'b1;
      else if (!peer_sem_held[port_addr[2:0]]) sem_own_n[port_addr[2:0]] <= 1'b0;
    end
  end

  // mailbox flags: set by the writing side; the left one cleared by the owner's read, the right one never cleared
  always @(posedge ref_clk) begin
    if (!port_ce_n && !port_oe_n && port_addr == 13'h1FFE) left_mailbox_flag_n <= 1'b1;
    else if (peer_mbox_write) left_mailbox_flag_n <= 1'b0;
    if (!port_ce_n && !port_rw_n && port_addr == 13'h1FFF) right_mailbox_flag_n <= 1'b0;
  end
endmodule : dpmc_dev_model

/* test/test_dpmc_host.sv */
`timescale 1ns/1ns
module test_dpmc_host;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h00000000;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [12:0] port_addr, peer_addr = 13'h0000;
  logic [15:0] port_data_in, port_data_out;
  logic port_data_oe, port_ce_n, port_sem_n, port_oe_n, port_rw_n, port_ub_n, port_lb_n;
  logic [1:0] port_busy_n, role_select;
  logic left_flag_n, right_flag_n, slave_busy_n;
  logic peer_active = 1'b0, peer_mbox_write = 1'b0;
  logic [7:0] peer_sem_held = 8'h00;
  int num_errors = 0, total_checks = 0;
  logic [31:0] seed = 32'hE982A783;
  logic [31:0] rd, r;
  logic [1:0] rsp;
  logic [12:0] a;
  localparam logic [5:0] MB = 6'h08;

  always #5 ref_clk = ~ref_clk;

  dpmc_host i_dut (.ref_clk(ref_clk), .reset(reset), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .port_addr(port_addr), .port_data_in(port_data_in), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .port_ce_n(port_ce_n), .port_flag_space_select_n(port_sem_n),
    .port_oe_n(port_oe_n), .port_rw_n(port_rw_n), .port_ub_n(port_ub_n), .port_lb_n(port_lb_n),
    .port_busy_n(port_busy_n), .left_mailbox_flag_n(left_flag_n),
    .role_select(role_select), .slave_busy_n(slave_busy_n));

  dpmc_dev_model i_model (.ref_clk(ref_clk), .port_addr(port_addr),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe), .port_ce_n(port_ce_n),
    .port_flag_space_select_n(port_sem_n), .port_oe_n(port_oe_n), .port_rw_n(port_rw_n),
    .port_data_in(port_data_in), .port_busy_n(port_busy_n), .left_mailbox_flag_n(left_flag_n),
    .right_mailbox_flag_n(right_flag_n), .peer_active(peer_active), .peer_addr(peer_addr),
    .peer_mbox_write(peer_mbox_write), .peer_sem_held(peer_sem_held));

  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic timed_out;
    num_errors++;
    $display("CHECK FAILED wait for answer expected answer seen none");
    wrap_up();
  endtask : timed_out

  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] ctrl_word(input logic [1:0] op, input logic [5:0] flags);
    return {26'h0000000, flags} | {30'h00000000, op} | (32'h1 << dpmc_pkg::CTRL_START);
  endfunction : ctrl_word

  // address and data offered together, each released once taken
  task automatic bus_write(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk);
    s_awaddr <= ad; s_awvalid <= 1'b1; s_wdata <= d; s_wvalid <= 1'b1; s_bready <= 1'b1;
    for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
      @(posedge ref_clk);
      if (s_awready === 1'b1 && !aw_ok) begin aw_ok = 1'b1; s_awvalid <= 1'b0; end
      if (s_wready === 1'b1 && !w_ok) begin w_ok = 1'b1; s_wvalid <= 1'b0; end
    end
    for (n = 0; n < 100 && s_bvalid !== 1'b1; n++) @(posedge ref_clk);
    if (n == 100 || !(aw_ok && w_ok)) timed_out();
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge ref_clk);
    s_araddr <= ad; s_arvalid <= 1'b1; s_rready <= 1'b1;
    n = 0;
    // hold the request until an edge at which ready is seen high
    do begin
      @(posedge ref_clk);
      n++;
    end while (s_arready !== 1'b1 && n < 100);
    s_arvalid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s_rvalid !== 1'b1 && n < 200);
    if (n >= 200) timed_out();
    d = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask : bus_read

  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
    logic [1:0] resp;
    bus_write(ad, d, resp);
    check("write response", 32'(resp), 32'(dpmc_pkg::RESP_OKAY));
  endtask : reg_wr

  task automatic wait_done;
    int n;
    logic [1:0] resp;
    for (n = 0; n < 100; n++) begin
      bus_read(dpmc_pkg::REG_STATUS, rd, resp);
      if (rd[dpmc_pkg::STAT_DONE] === 1'b1) break;
    end
    if (n == 100) timed_out();
    reg_wr(dpmc_pkg::REG_STATUS, 32'h00000002);
  endtask : wait_done

  task automatic run_op(input logic [1:0] op, input logic [12:0] ad, input logic [15:0] d,
                        input logic [5:0] flags);
    reg_wr(dpmc_pkg::REG_ADDR, {19'h00000, ad});
    reg_wr(dpmc_pkg::REG_WDATA, {16'h0000, d});
    reg_wr(dpmc_pkg::REG_CTRL, ctrl_word(op, flags));
    wait_done();
  endtask : run_op

  // main sequence: reset, registers, plain traffic, mailbox, busy, flags, straps
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    check("role straps", 32'(role_select), 32'h00000001);
    check("slave busy level", 32'(slave_busy_n), 32'h00000001);
    check("select idle", 32'({port_ce_n, port_sem_n}), 32'h00000003);
    bus_read(8'h14, rd, rsp);
    check("unmapped read response", 32'(rsp), 32'(dpmc_pkg::RESP_SLVERR));
    bus_write(8'h14, 32'h00000001, rsp);
    check("unmapped write response", 32'(rsp), 32'(dpmc_pkg::RESP_SLVERR));
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFD : {1'b0, r[11:0]};
      run_op(dpmc_pkg::OP_WRITE, a, r[31:16], 6'h00);
      check("stored word", 32'(i_model.mem[a]), 32'(r[31:16]));
      run_op(dpmc_pkg::OP_READ, a, 16'h0000, 6'h00);
      bus_read(dpmc_pkg::REG_RDATA, rd, rsp);
      check("read word", rd, {16'h0000, r[31:16]});
      check("standby after op", 32'({port_ce_n, port_sem_n}), 32'h00000003);
      check("lanes idle", 32'({port_ub_n, port_lb_n}), 32'h00000003);
    end
    run_op(dpmc_pkg::OP_WRITE, dpmc_pkg::MAILBOX_PEER_ADDR, 16'hA55A, MB);
    check("peer mailbox flag", 32'(right_flag_n), 32'h00000000);
    check("mailbox word", 32'(i_model.mem[13'h1FFF]), 32'h0000A55A);
    for (int k = 0; k < 2; k++) begin
      reg_wr(dpmc_pkg::REG_CTRL, (k == 0) ? {26'h0000000, MB} : 32'h00000000);
      @(posedge ref_clk) peer_mbox_write <= 1'b1;
      @(posedge ref_clk) peer_mbox_write <= 1'b0;
      repeat (3) @(posedge ref_clk);
      bus_read(dpmc_pkg::REG_STATUS, rd, rsp);
      check("mailbox pending", 32'(rd[dpmc_pkg::STAT_MAILBOX]), (k == 0) ? 32'h1 : 32'h0);
      run_op(dpmc_pkg::OP_READ, dpmc_pkg::MAILBOX_OWN_ADDR, 16'h0000, (k == 0) ? MB : 6'h00);
      bus_read(dpmc_pkg::REG_STATUS, rd, rsp);
      check("mailbox cleared", 32'(rd[dpmc_pkg::STAT_MAILBOX]), 32'h00000000);
      check("own flag level", 32'(left_flag_n), 32'h00000001);
    end
    a = 13'h0ABC;
    peer_addr <= a;
    peer_active <= 1'b1;
    reg_wr(dpmc_pkg::REG_ADDR, {19'h00000, a});
    reg_wr(dpmc_pkg::REG_WDATA, 32'h00001234);
    reg_wr(dpmc_pkg::REG_CTRL, ctrl_word(dpmc_pkg::OP_WRITE, 6'h00));
    repeat (3) bus_read(dpmc_pkg::REG_STATUS, rd, rsp);
    check("stalled status", rd & 32'h00000007, 32'h00000005);
    check("no strobe while busy", 32'(port_rw_n), 32'h00000001);
    check("data not driven", 32'(port_data_oe), 32'h00000000);
    check("lanes enabled", 32'({port_ub_n, port_lb_n}), 32'h00000000);
    peer_active <= 1'b0;
    wait_done();
    check("write after busy", 32'(i_model.mem[a]), 32'h00001234);
    bus_read(dpmc_pkg::REG_STATUS, rd, rsp);
    check("collision sticky", 32'(rd[dpmc_pkg::STAT_COLLISION]), 32'h00000001);
    reg_wr(dpmc_pkg::REG_STATUS, 32'h00000004);
    bus_read(dpmc_pkg::REG_STATUS, rd, rsp);
    check("collision cleared", 32'(rd[dpmc_pkg::STAT_COLLISION]), 32'h00000000);
    peer_sem_held <= 8'h08;
    for (int k = 0; k < 2; k++) begin
      run_op(dpmc_pkg::OP_SEM_TAKE, (k == 0) ? 13'h1FF5 : 13'h0003, 16'h0000, 6'h00);
      bus_read(dpmc_pkg::REG_STATUS, rd, rsp);
      check("token owned", 32'(rd[dpmc_pkg::STAT_SEM_OWNED]), (k == 0) ? 32'h1 : 32'h0);
      bus_read(dpmc_pkg::REG_RDATA, rd, rsp);
      check("flag read", rd, (k == 0) ? 32'h00000000 : 32'h0000FFFF);
    end
    check("flag held here", 32'(i_model.sem_own_n), 32'h000000DF);
    run_op(dpmc_pkg::OP_SEM_RELEASE, 13'h0005, 16'h0000, 6'h00);
    check("flag released", 32'(i_model.sem_own_n), 32'h000000FF);
    reg_wr(dpmc_pkg::REG_CTRL, 32'h00000030);
    @(posedge ref_clk);
    check("master strap moved", 32'(role_select), 32'h00000002);
    check("slave write block", 32'(slave_busy_n), 32'h00000000);
    reg_wr(dpmc_pkg::REG_CTRL, 32'h00000000);
    @(posedge ref_clk);
    check("slave normal", 32'(slave_busy_n), 32'h00000001);
    wrap_up();
  end
endmodule : test_dpmc_host
